/* File: hw/bsc_pkg.sv */
// Purpose: Constants and types for the bias and system control register bank
// Assumes: One 40 MHz core clock, registers reached over a plain strobe port
// Notes: Field positions count from bit 0 of each 8-bit register
package bsc_pkg;

  localparam logic [7:0] BIAS_ADDR = 8'h08;
  localparam logic [7:0] SYS_ADDR = 8'h09;
  localparam logic [7:0] BIAS_RESET = 8'h00;
  localparam logic [7:0] SYS_RESET = 8'h10;

  localparam int BIAS_LEVEL_BIT = 7;
  localparam int BIAS_CONN_MSB = 6;
  localparam int MON_MSB = 7;
  localparam int MON_LSB = 5;
  localparam int CAL_MSB = 4;
  localparam int CAL_LSB = 3;
  localparam int TIMEOUT_BIT = 2;
  localparam int CRC_BIT = 1;
  localparam int STAT_BIT = 0;

  localparam logic [1:0] PGA_EN_ON = 2'h1;
  localparam logic [4:0] CAL_COUNT_1 = 5'h01;
  localparam logic [4:0] CAL_COUNT_4 = 5'h04;
  localparam logic [4:0] CAL_COUNT_8 = 5'h08;
  localparam logic [4:0] CAL_COUNT_16 = 5'h10;

  // Polynomial and seed are plain defaults
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;

  typedef enum logic [2:0] {
    MON_OFF = 3'b000,
    MON_MIDSUPPLY = 3'b001,
    MON_TEMP = 3'b010,
    MON_ANALOG_SUPPLY = 3'b011,
    MON_DIGITAL_SUPPLY = 3'b100,
    MON_BURNOUT_LOW = 3'b101,
    MON_BURNOUT_MID = 3'b110,
    MON_BURNOUT_HIGH = 3'b111
  } bsc_mon_t;

  typedef enum logic [1:0] {
    CAL_SEL_1 = 2'b00,
    CAL_SEL_4 = 2'b01,
    CAL_SEL_8 = 2'b10,
    CAL_SEL_16 = 2'b11
  } bsc_cal_t;

  typedef enum logic [2:0] {
    RD_IDLE = 3'b000,
    RD_STATUS = 3'b001,
    RD_HIGH = 3'b010,
    RD_LOW = 3'b011,
    RD_CRC = 3'b100
  } bsc_rd_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bsc_bus_req_t;

  typedef struct packed {
    logic [15:0] result;
    logic [7:0] status;
    logic start;
  } bsc_conv_t;

  typedef struct packed {
    logic [7:0] data;
    logic valid;
    logic last;
  } bsc_byte_t;

  typedef struct packed {
    logic bias_level_select;
    logic [6:0] bias_connect;
    logic bias_gen_enable;
    logic mux_inputs_open;
    logic pga_to_midsupply;
    logic temp_sensor_enable;
    logic analog_supply_monitor;
    logic digital_supply_monitor;
    logic gain_force_one;
    logic burnout_enable;
    logic [1:0] burnout_level;
    logic [4:0] calibration_average_count;
    logic timeout_enable;
    logic crc_enable;
    logic status_byte_enable;
  } bsc_analog_ctrl_t;

endpackage

/* File: hw/bsc_regs.sv */
// Purpose: Bias select and system control registers with decoded controls
// Assumes: Bus master and conversion source run on core_clk
// Notes: Readout framer serialises one conversion into bytes
`timescale 1ns/10ps
module bsc_regs (
  input wire logic core_clk,
  input wire logic rstn,
  input wire bsc_pkg::bsc_bus_req_t bus_req,
  output logic [7:0] bus_rdata,
  input wire logic [1:0] amplifier_enable_field,
  input wire bsc_pkg::bsc_conv_t conv_in,
  output bsc_pkg::bsc_analog_ctrl_t analog_ctrl,
  output bsc_pkg::bsc_byte_t readout_byte,
  output logic readout_busy,
  output logic temp_amp_config_error
);

  typedef struct packed {
    logic [7:0] bias;
    logic [7:0] system_control;
    logic [7:0] rdata;
    bsc_pkg::bsc_analog_ctrl_t ctrl;
    logic temp_err;
    bsc_pkg::bsc_rd_state_t rd_state;
    logic [15:0] cap_result;
    logic [7:0] cap_status;
    logic cap_crc_en;
    logic [7:0] crc;
    bsc_pkg::bsc_byte_t out_byte;
    logic busy;
  } bsc_state_t;

  bsc_state_t state_q;
  bsc_state_t state_d;

  function automatic logic [7:0] bsc_crc_byte(input logic [7:0] crc_in,
                                              input logic [7:0] data);
    logic [7:0] c;
    c = crc_in ^ data;
    for (int i = 0; i < 8; i++) begin
      if (c[7]) begin
        c = {c[6:0], 1'b0} ^ bsc_pkg::CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction

  function automatic bsc_pkg::bsc_analog_ctrl_t bsc_decode(input logic [7:0] bias,
                                                          input logic [7:0] system_control);
    bsc_pkg::bsc_analog_ctrl_t c;
    bsc_pkg::bsc_mon_t mon;
    c = '0;
    mon = bsc_pkg::bsc_mon_t'(system_control[bsc_pkg::MON_MSB:bsc_pkg::MON_LSB]);
    c.bias_level_select = bias[bsc_pkg::BIAS_LEVEL_BIT];
    // Each bit drives its own switch, so any mix is legal
    c.bias_connect = bias[bsc_pkg::BIAS_CONN_MSB:0];
    c.bias_gen_enable = |bias[bsc_pkg::BIAS_CONN_MSB:0];
    case (mon)
      bsc_pkg::MON_OFF: begin
        c.mux_inputs_open = 1'b0;
      end
      bsc_pkg::MON_MIDSUPPLY: begin
        c.pga_to_midsupply = 1'b1;
        c.mux_inputs_open = 1'b1;
      end
      bsc_pkg::MON_TEMP: begin
        c.temp_sensor_enable = 1'b1;
        c.mux_inputs_open = 1'b1;
      end
      bsc_pkg::MON_ANALOG_SUPPLY: begin
        c.analog_supply_monitor = 1'b1;
        c.gain_force_one = 1'b1;
        c.mux_inputs_open = 1'b1;
      end
      bsc_pkg::MON_DIGITAL_SUPPLY: begin
        c.digital_supply_monitor = 1'b1;
        c.gain_force_one = 1'b1;
        c.mux_inputs_open = 1'b1;
      end
      bsc_pkg::MON_BURNOUT_LOW: begin
        c.burnout_enable = 1'b1;
        c.burnout_level = 2'h0;
      end
      bsc_pkg::MON_BURNOUT_MID: begin
        c.burnout_enable = 1'b1;
        c.burnout_level = 2'h1;
      end
      bsc_pkg::MON_BURNOUT_HIGH: begin
        c.burnout_enable = 1'b1;
        c.burnout_level = 2'h2;
      end
      default: begin
        c.mux_inputs_open = 1'b0;
      end
    endcase
    case (bsc_pkg::bsc_cal_t'(system_control[bsc_pkg::CAL_MSB:bsc_pkg::CAL_LSB]))
      bsc_pkg::CAL_SEL_1: c.calibration_average_count = bsc_pkg::CAL_COUNT_1;
      bsc_pkg::CAL_SEL_4: c.calibration_average_count = bsc_pkg::CAL_COUNT_4;
      bsc_pkg::CAL_SEL_8: c.calibration_average_count = bsc_pkg::CAL_COUNT_8;
      bsc_pkg::CAL_SEL_16: c.calibration_average_count = bsc_pkg::CAL_COUNT_16;
      default: c.calibration_average_count = bsc_pkg::CAL_COUNT_8;
    endcase
    c.timeout_enable = system_control[bsc_pkg::TIMEOUT_BIT];
    c.crc_enable = system_control[bsc_pkg::CRC_BIT];
    c.status_byte_enable = system_control[bsc_pkg::STAT_BIT];
    return c;
  endfunction

  always_comb begin
    state_d = state_q;
    state_d.rdata = 8'h00;
    state_d.out_byte = '0;

    // Register writes; values are held until the next write or reset
    if (bus_req.wr) begin
      case (bus_req.addr)
        bsc_pkg::BIAS_ADDR: state_d.bias = bus_req.wdata;
        bsc_pkg::SYS_ADDR: state_d.system_control = bus_req.wdata;
        default: state_d.bias = state_q.bias;
      endcase
    end

    // Read data stands for one cycle only; unmapped reads return zero
    if (bus_req.rd) begin
      case (bus_req.addr)
        bsc_pkg::BIAS_ADDR: state_d.rdata = state_q.bias;
        bsc_pkg::SYS_ADDR: state_d.rdata = state_q.system_control;
        default: state_d.rdata = 8'h00;
      endcase
    end

    // Decode from the next values so controls follow a write with no extra lag
    state_d.ctrl = bsc_decode(state_d.bias, state_d.system_control);

    // Temperature sensing needs the amplifier on; flag a bad host setup
    state_d.temp_err = state_d.ctrl.temp_sensor_enable &&
                       (amplifier_enable_field != bsc_pkg::PGA_EN_ON);

    // Framing is fixed at start so a mid-frame write cannot tear a readout
    case (state_q.rd_state)
      bsc_pkg::RD_IDLE: begin
        if (conv_in.start) begin
          state_d.cap_result = conv_in.result;
          state_d.cap_status = conv_in.status;
          state_d.cap_crc_en = state_q.ctrl.crc_enable;
          state_d.crc = bsc_pkg::CRC_INIT;
          if (state_q.ctrl.status_byte_enable) begin
            state_d.rd_state = bsc_pkg::RD_STATUS;
          end else begin
            state_d.rd_state = bsc_pkg::RD_HIGH;
          end
        end
      end
      bsc_pkg::RD_STATUS: begin
        state_d.out_byte.data = state_q.cap_status;
        state_d.out_byte.valid = 1'b1;
        state_d.crc = bsc_crc_byte(state_q.crc, state_q.cap_status);
        state_d.rd_state = bsc_pkg::RD_HIGH;
      end
      bsc_pkg::RD_HIGH: begin
        state_d.out_byte.data = state_q.cap_result[15:8];
        state_d.out_byte.valid = 1'b1;
        state_d.crc = bsc_crc_byte(state_q.crc, state_q.cap_result[15:8]);
        state_d.rd_state = bsc_pkg::RD_LOW;
      end
      bsc_pkg::RD_LOW: begin
        state_d.out_byte.data = state_q.cap_result[7:0];
        state_d.out_byte.valid = 1'b1;
        state_d.out_byte.last = !state_q.cap_crc_en;
        state_d.crc = bsc_crc_byte(state_q.crc, state_q.cap_result[7:0]);
        if (state_q.cap_crc_en) begin
          state_d.rd_state = bsc_pkg::RD_CRC;
        end else begin
          state_d.rd_state = bsc_pkg::RD_IDLE;
        end
      end
      bsc_pkg::RD_CRC: begin
        state_d.out_byte.data = state_q.crc;
        state_d.out_byte.valid = 1'b1;
        state_d.out_byte.last = 1'b1;
        state_d.rd_state = bsc_pkg::RD_IDLE;
      end
      default: begin
        state_d.rd_state = bsc_pkg::RD_IDLE;
      end
    endcase
    state_d.busy = (state_d.rd_state != bsc_pkg::RD_IDLE);
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= '0;
      state_q.bias <= bsc_pkg::BIAS_RESET;
      state_q.system_control <= bsc_pkg::SYS_RESET;
      state_q.ctrl.calibration_average_count <= bsc_pkg::CAL_COUNT_8;
      state_q.rd_state <= bsc_pkg::RD_IDLE;
      state_q.crc <= bsc_pkg::CRC_INIT;
    end else begin
      state_q <= state_d;
    end
  end

  assign bus_rdata = state_q.rdata;
  assign analog_ctrl = state_q.ctrl;
  assign readout_byte = state_q.out_byte;
  assign readout_busy = state_q.busy;
  assign temp_amp_config_error = state_q.temp_err;

endmodule

/* File: testbench/bsc_host.sv */
// Purpose: Host model on the register strobe port
// Assumes: Tasks are entered right after a rising edge
// Notes: A gap cycle follows each write so no signal is set twice
`timescale 1ns/10ps
module bsc_host (
  input wire logic core_clk,
  output bsc_pkg::bsc_bus_req_t bus_req,
  input wire logic [7:0] bus_rdata
);
  initial bus_req = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus_req <= '{addr: ~a, wdata: ~v, wr: 1'b0, rd: 1'b0};
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus_req <= '{addr: ~a, wdata: 8'hA5, wr: 1'b0, rd: 1'b0};
    @(posedge core_clk);
    v = bus_rdata;
  endtask
endmodule

/* File: testbench/bsc_regs_monitor.sv */
// Purpose: Port checker for the bias and system control bank
// Assumes: Sees only the top ports, one clock domain
// Notes: Decoded outputs are tied to their register cause
`timescale 1ns/10ps
module bsc_regs_monitor (
  input wire logic core_clk,
  input wire logic rstn,
  input wire bsc_pkg::bsc_bus_req_t bus_req,
  input wire logic [7:0] bus_rdata,
  input wire logic [1:0] amplifier_enable_field,
  input wire bsc_pkg::bsc_conv_t conv_in,
  input wire bsc_pkg::bsc_analog_ctrl_t analog_ctrl,
  input wire bsc_pkg::bsc_byte_t readout_byte,
  input wire logic readout_busy,
  input wire logic temp_amp_config_error
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  rdata_idle_a: assert property (!$past(bus_req.rd) |-> bus_rdata == 8'h00)
    else $error("read data outside slot");
  bias_read_a: assert property (
    $past(bus_req.rd && bus_req.addr == bsc_pkg::BIAS_ADDR) |->
    bus_rdata == $past({analog_ctrl.bias_level_select, analog_ctrl.bias_connect}))
    else $error("bias readback differs");
  sys_write_a: assert property (
    $past(bus_req.wr && bus_req.addr == bsc_pkg::SYS_ADDR) |->
    {analog_ctrl.timeout_enable, analog_ctrl.crc_enable, analog_ctrl.status_byte_enable}
    == $past(bus_req.wdata[2:0]))
    else $error("system enables not updated");
  bias_gen_a: assert property (
    analog_ctrl.bias_gen_enable == (|analog_ctrl.bias_connect))
    else $error("bias generator enable wrong");
  ctrl_hold_a: assert property (!$past(bus_req.wr) |-> $stable(analog_ctrl))
    else $error("controls moved without write");
  mux_open_a: assert property (
    analog_ctrl.mux_inputs_open == (analog_ctrl.pga_to_midsupply
    | analog_ctrl.temp_sensor_enable | analog_ctrl.analog_supply_monitor
    | analog_ctrl.digital_supply_monitor))
    else $error("input switches wrong");
  gain_one_a: assert property (
    analog_ctrl.gain_force_one == (analog_ctrl.analog_supply_monitor
    | analog_ctrl.digital_supply_monitor))
    else $error("gain force wrong");
  temp_err_a: assert property (
    temp_amp_config_error == (analog_ctrl.temp_sensor_enable
    && $past(amplifier_enable_field) != bsc_pkg::PGA_EN_ON))
    else $error("amplifier flag wrong");
  frame_start_a: assert property (
    conv_in.start && !readout_busy |-> ##2 readout_byte.valid)
    else $error("first byte late");
  cover property (bus_req.rd && bus_req.addr == bsc_pkg::BIAS_ADDR);
  cover property (readout_byte.valid && readout_byte.last);
  cover property (conv_in.start && !readout_busy);
  cover property (temp_amp_config_error);
endmodule
bind bsc_regs bsc_regs_monitor i_mon (.core_clk(core_clk), .rstn(rstn), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .amplifier_enable_field(amplifier_enable_field),
  .conv_in(conv_in), .analog_ctrl(analog_ctrl), .readout_byte(readout_byte),
  .readout_busy(readout_busy), .temp_amp_config_error(temp_amp_config_error));

/* File: testbench/tb.sv */
// Purpose: Self-checking bench for the bias and system control bank
// Assumes: Host model drives the strobe port
// Notes: Random register pairs from a fixed seed plus corner values
`timescale 1ns/10ps
module tb;
  logic core_clk, rstn;
  logic [1:0] amp;
  logic [7:0] rdata, b, s, rdata_unused;
  bsc_pkg::bsc_bus_req_t bus_req;
  bsc_pkg::bsc_conv_t conv_in;
  bsc_pkg::bsc_analog_ctrl_t ctl;
  bsc_pkg::bsc_byte_t ob;
  logic busy, terr;
  int fails, n_compared;
  bsc_host i_host (.core_clk(core_clk), .bus_req(bus_req), .bus_rdata(rdata));
  bsc_regs i_dut (.core_clk(core_clk), .rstn(rstn), .bus_req(bus_req), .bus_rdata(rdata),
    .amplifier_enable_field(amp), .conv_in(conv_in), .analog_ctrl(ctl), .readout_byte(ob),
    .readout_busy(busy), .temp_amp_config_error(terr));
  function automatic bsc_pkg::bsc_analog_ctrl_t ectl(logic [7:0] b, logic [7:0] s);
    bsc_pkg::bsc_analog_ctrl_t c;
    logic [2:0] m;
    m = s[7:5];
    c = '0;
    c.bias_level_select = b[7];
    c.bias_connect = b[6:0];
    c.bias_gen_enable = |b[6:0];
    c.mux_inputs_open = m inside {3'h1, 3'h2, 3'h3, 3'h4};
    c.pga_to_midsupply = m == 3'h1;
    c.temp_sensor_enable = m == 3'h2;
    c.analog_supply_monitor = m == 3'h3;
    c.digital_supply_monitor = m == 3'h4;
    c.gain_force_one = m inside {3'h3, 3'h4};
    c.burnout_enable = m[2] & |m[1:0];
    c.burnout_level = c.burnout_enable ? m[1:0] - 2'h1 : 2'h0;
    c.calibration_average_count = s[4:3] == 2'h0 ? 5'h01 : 5'h01 << ({1'b0, s[4:3]} + 3'h1);
    c.timeout_enable = s[2];
    c.crc_enable = s[1];
    c.status_byte_enable = s[0];
    return c;
  endfunction
  function automatic logic [7:0] crc8(logic [7:0] c, logic [7:0] v);
    c = c ^ v;
    repeat (8) c = c[7] ? (c << 1) ^ bsc_pkg::CRC_POLY : c << 1;
    return c;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic final_report();
    if (fails == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic rcheck(input logic [7:0] eb, input logic [7:0] es);
    logic [7:0] v;
    chk(32'(ctl), 32'(ectl(eb, es)));
    i_host.rd(bsc_pkg::BIAS_ADDR, v);
    chk(32'(v), 32'(eb));
    i_host.rd(bsc_pkg::SYS_ADDR, v);
    chk(32'(v), 32'(es));
  endtask
  task automatic frame(input logic [1:0] en);
    logic [7:0] q[$];
    logic [7:0] c;
    logic [15:0] r;
    logic [7:0] st;
    int k;
    r = 16'($urandom);
    st = 8'($urandom);
    c = bsc_pkg::CRC_INIT;
    k = 0;
    if (en[0]) q.push_back(st);
    q.push_back(r[15:8]);
    q.push_back(r[7:0]);
    foreach (q[j]) c = crc8(c, q[j]);
    if (en[1]) q.push_back(c);
    conv_in <= '{result: r, status: st, start: 1'b1};
    for (int n = 0; n < 8; n++) begin
      @(posedge core_clk);
      chk(32'(busy), 32'(n >= 1 && n <= q.size()));
      chk(32'(ob.valid), 32'(n >= 2 && n <= q.size() + 1));
      if (ob.valid === 1'b1) begin
        chk(32'(ob.data), 32'(q[k]));
        chk(32'(ob.last), 32'(k == q.size() - 1));
        k++;
      end
      // A second start lands while busy and must be dropped
      conv_in <= '{result: ~r, status: ~st, start: n == 0};
    end
    chk(32'(k), 32'(q.size()));
  endtask
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    fails++;
    final_report();
  end
  initial begin
    rstn = 1'b0;
    amp = 2'h0;
    conv_in = '0;
    void'($urandom(9));
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    rcheck(8'h00, 8'h10);
    for (int i = 0; i < 40; i++) begin
      b = i == 1 ? 8'h00 : i == 2 ? 8'hFF : 8'($urandom);
      s = 8'($urandom);
      if (i < 32) s[7:3] = i[4:0];
      amp <= 2'($urandom);
      i_host.wr(bsc_pkg::BIAS_ADDR, b);
      i_host.wr(bsc_pkg::SYS_ADDR, s);
      i_host.wr(8'h0A, ~b);
      rcheck(b, s);
      i_host.rd(8'h0A, rdata_unused);
      chk(32'(rdata_unused), 32'h0);
      chk(32'(terr), 32'(s[7:5] == 3'h2 && amp != bsc_pkg::PGA_EN_ON));
      frame(s[1:0]);
    end
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    rcheck(8'h00, 8'h10);
    final_report();
  end
endmodule
